// *** shared/tcc_pkg.sv ***
`default_nettype none
package tcc_pkg;
  localparam int NUM_CMP     = 3;
  localparam int DATA_W      = 16;
  localparam int ADDR_W      = 4;
  localparam int SYNC_STAGES = 2;

  // Register indices on the plain register port
  localparam logic [ADDR_W-1:0] IDX_CTL_ONE   = 4'h0;
  localparam logic [ADDR_W-1:0] IDX_CTL_TWO   = 4'h1;
  localparam logic [ADDR_W-1:0] IDX_CTL_THREE = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_STATUS    = 4'h3;
  localparam logic [ADDR_W-1:0] IDX_LADDER    = 4'h4;
  localparam logic [ADDR_W-1:0] IDX_IRQ_STAT  = 4'h5;
  localparam logic [ADDR_W-1:0] IDX_IRQ_MASK  = 4'h6;

  // Comparator control fields
  localparam int CTL_ON_BIT    = 15;
  localparam int CTL_PIN_BIT   = 14;
  localparam int CTL_INV_BIT   = 13;
  localparam int CTL_EVT_BIT   = 9;
  localparam int CTL_RES_BIT   = 8;
  localparam int CTL_EDGE_LSB  = 6;
  localparam int CTL_PLUS_BIT  = 4;
  localparam int CTL_MINUS_LSB = 0;

  // Shared status fields
  localparam int STAT_IDLE_BIT = 15;
  localparam int STAT_EVT_LSB  = 8;
  localparam int STAT_RES_LSB  = 0;

  // Ladder control fields
  localparam int LAD_EXT_BIT   = 10;
  localparam int LAD_BG_LSB    = 8;
  localparam int LAD_PWR_BIT   = 7;
  localparam int LAD_PIN_BIT   = 6;
  localparam int LAD_RANGE_BIT = 5;
  localparam int LAD_SUP_BIT   = 4;
  localparam int LAD_LVL_LSB   = 0;
  localparam int LAD_LVL_W     = 4;

  // Implemented bits; everything else reads zero
  localparam logic [DATA_W-1:0] CTL_READ_MASK  = 16'hE3D3;
  localparam logic [DATA_W-1:0] CTL_STORE_MASK = 16'hE0D3;
  localparam logic [DATA_W-1:0] STAT_WR_MASK   = 16'h8000;
  localparam logic [DATA_W-1:0] LAD_WR_MASK    = 16'h07FF;
  localparam logic [DATA_W-1:0] RESET_WORD     = 16'h0000;

  // Ladder step denominators: coarse and fine range
  localparam logic [5:0] LAD_DIV_COARSE = 6'h18;
  localparam logic [5:0] LAD_DIV_FINE   = 6'h20;

  typedef enum logic [1:0] {
    TCC_EDGE_OFF  = 2'b00,
    TCC_EDGE_RISE = 2'b01,
    TCC_EDGE_FALL = 2'b10,
    TCC_EDGE_ANY  = 2'b11
  } tcc_edge_t;
endpackage : tcc_pkg
`default_nettype wire

// *** rtl/tcc_sync.sv ***
`default_nettype none
module tcc_sync (
  input  wire logic                       sys_clk,
  input  wire logic                       resetn,
  input  wire logic [tcc_pkg::NUM_CMP-1:0] async_in,
  output var  logic [tcc_pkg::NUM_CMP-1:0] sync_out
);
  import tcc_pkg::*;

  logic [NUM_CMP-1:0] meta_reg;
  logic [NUM_CMP-1:0] sync_reg;

  // First stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= async_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;
endmodule : tcc_sync
`default_nettype wire

// *** rtl/tcc_channel.sv ***
`default_nettype none
module tcc_channel (
  input  wire logic               sys_clk,
  input  wire logic               resetn,
  input  wire logic               raw_sync,
  input  wire logic               comparator_on,
  input  wire logic               run,
  input  wire logic               result_invert,
  input  wire tcc_pkg::tcc_edge_t event_edge_select,
  input  wire logic               event_wr,
  input  wire logic               event_wr_val,
  output var  logic               comparator_result,
  output var  logic               event_flag,
  output var  logic               event_pulse
);
  import tcc_pkg::*;

  logic result_reg;
  logic result_next;
  logic flag_reg;
  logic pulse_reg;
  logic rise;
  logic fall;
  logic hit;

  // Halted comparator holds its last result; disabled one reads low
  always_comb begin
    if (!comparator_on) begin
      result_next = 1'b0;
    end else if (run) begin
      result_next = raw_sync ^ result_invert;
    end else begin
      result_next = result_reg;
    end
  end

  // Edges seen after inversion, so polarity steers the edge sense
  assign rise = run & ~result_reg & result_next;
  assign fall = run & result_reg & ~result_next;

  always_comb begin
    unique case (event_edge_select)
      TCC_EDGE_OFF:  hit = 1'b0;
      TCC_EDGE_RISE: hit = rise;
      TCC_EDGE_FALL: hit = fall;
      TCC_EDGE_ANY:  hit = rise | fall;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      result_reg <= 1'b0;
    end else begin
      result_reg <= result_next;
    end
  end

  // A trigger sets only a clear flag; a software clear of a set flag beats a trigger in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      flag_reg <= 1'b0;
    end else if (hit && !flag_reg) begin
      flag_reg <= 1'b1;
    end else if (event_wr) begin
      flag_reg <= event_wr_val;
    end
  end

  // No new pulse while the flag is still up
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      pulse_reg <= 1'b0;
    end else begin
      pulse_reg <= hit & ~flag_reg;
    end
  end

  assign comparator_result = result_reg;
  assign event_flag        = flag_reg;
  assign event_pulse       = pulse_reg;
endmodule : tcc_channel
`default_nettype wire

// *** rtl/tcc_top.sv ***
`default_nettype none
// Notes on behaviour
// - Three comparators, own controls, one status
// - Pin drive on routes raw result out
// - Plus input: ladder when set, pin A
// - Minus input select: B, C, D, reference
// - Edge select: off, rise, fall, any
// - Event flag sticks, blocks further triggers
// - Status bits 8-10 mirror event flags
// - Status bits 0-2 mirror results
// - Idle halt bit stops comparators in idle
// - Bandgap field: full, half, sixth, pin
// - Ladder pin drive bit outputs ladder voltage
// - Ladder: two ranges, sixteen levels each
// - Range bit: twenty-fourths or thirty-seconds
// - Supply select: reference pins or rails
// - Unimplemented bits read zero, ignore writes
module tcc_top (
  input  wire logic                                 sys_clk,
  input  wire logic                                 resetn,
  input  wire logic [tcc_pkg::ADDR_W-1:0]           reg_addr,
  input  wire logic [tcc_pkg::DATA_W-1:0]           reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  output var  logic [tcc_pkg::DATA_W-1:0]           reg_rdata,
  input  wire logic [tcc_pkg::NUM_CMP-1:0]          comparator_raw,
  input  wire logic                                 device_idle,
  output var  logic [tcc_pkg::NUM_CMP-1:0]          comparator_power,
  output var  logic [tcc_pkg::NUM_CMP-1:0]          plus_input_source,
  output var  logic [2*tcc_pkg::NUM_CMP-1:0]        minus_input_select,
  output var  logic [tcc_pkg::NUM_CMP-1:0]          result_pin,
  output var  logic [tcc_pkg::NUM_CMP-1:0]          result_pin_oe,
  output var  logic [1:0]                           bandgap_source_select,
  output var  logic                                 external_ref_pick,
  output var  logic                                 ladder_power,
  output var  logic                                 ladder_pin_drive,
  output var  logic                                 ladder_range,
  output var  logic                                 ladder_supply_select,
  output var  logic [tcc_pkg::LAD_LVL_W-1:0]        ladder_level,
  output var  logic [5:0]                           ladder_divisor,
  output var  logic                                 irq
);
  import tcc_pkg::*;

  function automatic logic [ADDR_W-1:0] ctl_idx(input int n);
    ctl_idx = IDX_CTL_ONE + ADDR_W'(n);
  endfunction : ctl_idx

  function automatic logic wr_hit(input logic             wr,
                                  input logic [ADDR_W-1:0] a,
                                  input logic [ADDR_W-1:0] idx);
    wr_hit = wr && (a == idx);
  endfunction : wr_hit

  logic [DATA_W-1:0]  ctl_reg [NUM_CMP];
  logic [DATA_W-1:0]  stat_reg;
  logic [DATA_W-1:0]  ladder_reg;
  logic [NUM_CMP-1:0] irq_stat_reg;
  logic [NUM_CMP-1:0] irq_mask_reg;
  logic [NUM_CMP-1:0] power_reg;
  logic [5:0]         divisor_reg;
  logic               irq_reg;
  logic [DATA_W-1:0]  rdata_reg;
  logic [DATA_W-1:0]  read_word;
  logic [NUM_CMP-1:0] raw_sync;
  logic [NUM_CMP-1:0] results;
  logic [NUM_CMP-1:0] flags;
  logic [NUM_CMP-1:0] evt_pulse;
  logic [NUM_CMP-1:0] power_next;
  logic [NUM_CMP-1:0] irq_clear;
  logic               halt;

  tcc_sync u_sync (
    .sys_clk  (sys_clk),
    .resetn   (resetn),
    .async_in (comparator_raw),
    .sync_out (raw_sync)
  );

  assign halt = stat_reg[STAT_IDLE_BIT] & device_idle;

  genvar g;
  generate
    for (g = 0; g < NUM_CMP; g++) begin : g_cmp
      assign power_next[g] = ctl_reg[g][CTL_ON_BIT] & ~halt;

      tcc_channel u_chan (
        .sys_clk           (sys_clk),
        .resetn            (resetn),
        .raw_sync          (raw_sync[g]),
        .comparator_on     (ctl_reg[g][CTL_ON_BIT]),
        .run               (power_next[g]),
        .result_invert     (ctl_reg[g][CTL_INV_BIT]),
        .event_edge_select (tcc_edge_t'(ctl_reg[g][CTL_EDGE_LSB +: 2])),
        .event_wr          (wr_hit(reg_wr, reg_addr, ctl_idx(g))),
        .event_wr_val      (reg_wdata[CTL_EVT_BIT]),
        .comparator_result (results[g]),
        .event_flag        (flags[g]),
        .event_pulse       (evt_pulse[g])
      );

      // Analog mux selects come straight from the control bits
      assign plus_input_source[g] = ctl_reg[g][CTL_PLUS_BIT];
      assign minus_input_select[2*g +: 2] =
        ctl_reg[g][CTL_MINUS_LSB +: 2];
      assign result_pin_oe[g] = ctl_reg[g][CTL_PIN_BIT];
      // Unsynchronised by design: the pad sees the analog edge directly
      assign result_pin[g] = comparator_raw[g] ^ ctl_reg[g][CTL_INV_BIT];
    end
  endgenerate

  // Bits 9 and 8 live in the channels, so they are never stored here
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      for (int i = 0; i < NUM_CMP; i++) begin
        ctl_reg[i] <= RESET_WORD;
      end
    end else begin
      for (int i = 0; i < NUM_CMP; i++) begin
        if (wr_hit(reg_wr, reg_addr, ctl_idx(i))) begin
          ctl_reg[i] <= reg_wdata & CTL_STORE_MASK;
        end
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      stat_reg <= RESET_WORD;
    end else if (wr_hit(reg_wr, reg_addr, IDX_STATUS)) begin
      stat_reg <= reg_wdata & STAT_WR_MASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      ladder_reg <= RESET_WORD;
    end else if (wr_hit(reg_wr, reg_addr, IDX_LADDER)) begin
      ladder_reg <= reg_wdata & LAD_WR_MASK;
    end
  end

  // Step size tracks the range bit for the analog ladder trim
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      divisor_reg <= LAD_DIV_FINE;
    end else if (ladder_reg[LAD_RANGE_BIT]) begin
      divisor_reg <= LAD_DIV_COARSE;
    end else begin
      divisor_reg <= LAD_DIV_FINE;
    end
  end

  // Registered so the analog enables never glitch on idle entry
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      power_reg <= '0;
    end else begin
      power_reg <= power_next;
    end
  end

  always_comb begin
    irq_clear = '0;
    if (wr_hit(reg_wr, reg_addr, IDX_IRQ_STAT)) begin
      irq_clear = reg_wdata[NUM_CMP-1:0];
    end
  end

  // Set after clear, so an event in the clearing cycle survives
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irq_stat_reg <= '0;
    end else begin
      irq_stat_reg <= (irq_stat_reg & ~irq_clear) | evt_pulse;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irq_mask_reg <= '0;
    end else if (wr_hit(reg_wr, reg_addr, IDX_IRQ_MASK)) begin
      irq_mask_reg <= reg_wdata[NUM_CMP-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      irq_reg <= 1'b0;
    end else begin
      irq_reg <= |(irq_stat_reg & irq_mask_reg);
    end
  end

  always_comb begin
    read_word = RESET_WORD;
    unique case (reg_addr)
      IDX_CTL_ONE, IDX_CTL_TWO, IDX_CTL_THREE: begin
        for (int i = 0; i < NUM_CMP; i++) begin
          if (reg_addr == ctl_idx(i)) begin
            read_word = ctl_reg[i] & CTL_READ_MASK;
            read_word[CTL_EVT_BIT] = flags[i];
            read_word[CTL_RES_BIT] = results[i];
          end
        end
      end
      IDX_STATUS: begin
        read_word = stat_reg;
        read_word[STAT_EVT_LSB +: NUM_CMP] = flags;
        read_word[STAT_RES_LSB +: NUM_CMP] = results;
      end
      IDX_LADDER: begin
        read_word = ladder_reg;
      end
      IDX_IRQ_STAT: begin
        read_word[NUM_CMP-1:0] = irq_stat_reg;
      end
      IDX_IRQ_MASK: begin
        read_word[NUM_CMP-1:0] = irq_mask_reg;
      end
      default: begin
        read_word = RESET_WORD;
      end
    endcase
  end

  // Read data stand for exactly one cycle, zero otherwise
  always_ff @(posedge sys_clk) begin
    if (!resetn) begin
      rdata_reg <= RESET_WORD;
    end else if (reg_rd) begin
      rdata_reg <= read_word;
    end else begin
      rdata_reg <= RESET_WORD;
    end
  end

  assign reg_rdata             = rdata_reg;
  assign comparator_power      = power_reg;
  assign external_ref_pick     = ladder_reg[LAD_EXT_BIT];
  assign bandgap_source_select = ladder_reg[LAD_BG_LSB +: 2];
  assign ladder_power          = ladder_reg[LAD_PWR_BIT];
  assign ladder_pin_drive      = ladder_reg[LAD_PIN_BIT];
  assign ladder_range          = ladder_reg[LAD_RANGE_BIT];
  assign ladder_supply_select  = ladder_reg[LAD_SUP_BIT];
  assign ladder_level = ladder_reg[LAD_LVL_LSB +: LAD_LVL_W];
  assign ladder_divisor        = divisor_reg;
  assign irq                   = irq_reg;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  a_ctl_result_read: assert property (
    reg_rd && reg_addr == IDX_CTL_THREE
    |=> reg_rdata[CTL_RES_BIT] == $past(results[2])
  ) else $error("control read lost result bit");

  a_pin_drive_on: assert property (
    wr_hit(reg_wr, reg_addr, IDX_CTL_ONE) && reg_wdata[CTL_PIN_BIT]
    |=> result_pin_oe[0]
  ) else $error("pin drive not enabled");

  a_plus_select: assert property (
    wr_hit(reg_wr, reg_addr, IDX_CTL_TWO)
    |=> plus_input_source[1] == $past(reg_wdata[CTL_PLUS_BIT])
  ) else $error("plus input select wrong");

  a_minus_select: assert property (
    wr_hit(reg_wr, reg_addr, IDX_CTL_THREE)
    |=> minus_input_select[5:4] == $past(reg_wdata[1:0])
  ) else $error("minus input select wrong");

  a_rise_sets_flag: assert property (
    $past(!flags[0]) && $past(ctl_reg[0][7:6]) == 2'b01
    && $rose(results[0]) |-> flags[0]
  ) else $error("rising event not flagged");

  a_flag_suppress: assert property (
    flags[0] |=> !evt_pulse[0]
  ) else $error("trigger while flag set");

  a_flag_sticks: assert property (
    flags[1] && !wr_hit(reg_wr, reg_addr, IDX_CTL_TWO) |=> flags[1]
  ) else $error("event flag dropped alone");

  a_status_events: assert property (
    reg_rd && reg_addr == IDX_STATUS
    |=> reg_rdata[10:8] == $past(flags)
  ) else $error("status event mirror wrong");

  a_status_results: assert property (
    reg_rd && reg_addr == IDX_STATUS
    |=> reg_rdata[2:0] == $past(results)
  ) else $error("status result mirror wrong");

  a_idle_halts: assert property (
    stat_reg[STAT_IDLE_BIT] && device_idle |=> comparator_power == 3'b000
  ) else $error("comparators run in idle");

  a_bandgap_field: assert property (
    wr_hit(reg_wr, reg_addr, IDX_LADDER)
    |=> bandgap_source_select == $past(reg_wdata[9:8])
  ) else $error("bandgap select wrong");

  a_ladder_pin: assert property (
    wr_hit(reg_wr, reg_addr, IDX_LADDER)
    |=> ladder_pin_drive == $past(reg_wdata[6])
  ) else $error("ladder pin drive wrong");

  a_ladder_level: assert property (
    wr_hit(reg_wr, reg_addr, IDX_LADDER)
    |=> ladder_level == $past(reg_wdata[3:0])
  ) else $error("ladder level wrong");

  a_range_divisor: assert property (
    ladder_range |=> ladder_divisor == 6'h18
  ) else $error("coarse step not chosen");

  a_supply_select: assert property (
    wr_hit(reg_wr, reg_addr, IDX_LADDER)
    |=> ladder_supply_select == $past(reg_wdata[4])
  ) else $error("ladder supply select wrong");

  a_unimpl_zero: assert property (
    reg_rd && reg_addr == IDX_CTL_ONE |=> (reg_rdata & ~CTL_READ_MASK) == '0
  ) else $error("unimplemented bits read nonzero");

  a_off_result_low: assert property (
    !ctl_reg[0][CTL_ON_BIT] |=> !results[0] && !comparator_power[0]
  ) else $error("disabled comparator active");

  a_ladder_power: assert property (
    wr_hit(reg_wr, reg_addr, IDX_LADDER)
    |=> ladder_power == $past(reg_wdata[7])
  ) else $error("ladder power wrong");

  a_irq_level: assert property (
    |(irq_stat_reg & irq_mask_reg) |=> irq
  ) else $error("masked interrupt not raised");

  c_event_flag: cover property (!flags[0] ##1 flags[0]);
  c_irq_raise: cover property (!irq ##1 irq);
  c_idle_halt: cover property (power_reg[1] ##1 halt ##1 !power_reg[1]);
  c_flag_clear: cover property (flags[2] ##1 !flags[2]);
endmodule : tcc_top
`default_nettype wire

// *** testbench/tcc_analog_model.sv ***
`default_nettype none
module tcc_analog_model (
  input  wire logic [tcc_pkg::NUM_CMP-1:0] target,
  input  wire logic                        slow,
  output var  logic [tcc_pkg::NUM_CMP-1:0] comparator_raw
);
  timeunit 1ns;
  timeprecision 100ps;
  import tcc_pkg::*;

  // Analog outputs settle after a delay, never in step with the clock
  initial comparator_raw = 3'h0;

  always @(target) begin
    if (slow) begin
      comparator_raw <= #7.3 target;
    end else begin
      comparator_raw <= #1.2 target;
    end
  end
endmodule : tcc_analog_model
`default_nettype wire

// *** testbench/tb_triple_comparator_control.sv ***
`default_nettype none
module tb_triple_comparator_control;
  timeunit 1ns;
  timeprecision 100ps;
  import tcc_pkg::*;

  logic                 sys_clk;
  logic                 resetn;
  logic [ADDR_W-1:0]    reg_addr;
  logic [DATA_W-1:0]    reg_wdata;
  logic                 reg_wr;
  logic                 reg_rd;
  logic [DATA_W-1:0]    reg_rdata;
  logic [NUM_CMP-1:0]   target;
  logic                 slow;
  logic [NUM_CMP-1:0]   raw;
  logic                 device_idle;
  logic [NUM_CMP-1:0]   cpwr;
  logic [NUM_CMP-1:0]   plus_src;
  logic [2*NUM_CMP-1:0] minus_sel;
  logic [NUM_CMP-1:0]   rpin;
  logic [NUM_CMP-1:0]   rpin_oe;
  logic [1:0]           bg_sel;
  logic                 ext_pick;
  logic                 lad_pwr;
  logic                 lad_pin;
  logic                 lad_rng;
  logic                 lad_sup;
  logic [LAD_LVL_W-1:0] lad_lvl;
  logic [5:0]           lad_div;
  logic                 irq;
  int                   err_count;
  int                   checked;
  // Reference model state, one entry per comparator
  int res[3], flg[3], on[3], inv[3], edg[3], rawm[3];
  int istat, imask, halt, idle;

  tcc_analog_model u_analog (.target(target), .slow(slow),
                             .comparator_raw(raw));

  tcc_top dut_u (
    .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .comparator_raw(raw),
    .device_idle(device_idle), .comparator_power(cpwr),
    .plus_input_source(plus_src), .minus_input_select(minus_sel),
    .result_pin(rpin), .result_pin_oe(rpin_oe),
    .bandgap_source_select(bg_sel), .external_ref_pick(ext_pick),
    .ladder_power(lad_pwr), .ladder_pin_drive(lad_pin),
    .ladder_range(lad_rng), .ladder_supply_select(lad_sup),
    .ladder_level(lad_lvl), .ladder_divisor(lad_div), .irq(irq)
  );

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  task automatic final_report();
    if (err_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t reg got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_reg

  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t pin got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_pin

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge sys_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    chk_reg(reg_rdata, exp);
  endtask : rd_chk

  // A halted comparator keeps its result; catching up later may be an edge
  function automatic void step(input int c);
    int nr;
    nr = (on[c] != 0) ? (rawm[c] ^ inv[c]) : 0;
    if (on[c] != 0 && halt != 0 && idle != 0) nr = res[c];
    if (nr != res[c] && flg[c] == 0 && (edg[c] == 3 ||
        (edg[c] == 1 && nr == 1) || (edg[c] == 2 && nr == 0))) begin
      flg[c] = 1;
      istat  = istat | (1 << c);
    end
    res[c] = nr;
  endfunction : step

  function automatic logic [15:0] stat_exp();
    logic [15:0] s;
    s     = 16'h0000;
    s[15] = (halt != 0);
    for (int k = 0; k < 3; k++) begin
      s[8+k] = (flg[k] != 0);
      s[k]   = (res[k] != 0);
    end
    return s;
  endfunction : stat_exp

  function automatic logic [7:0] pwr_exp();
    logic [7:0] p;
    p = 8'h00;
    for (int k = 0; k < 3; k++) begin
      p[k] = (on[k] != 0) && !(halt != 0 && idle != 0);
    end
    return p;
  endfunction : pwr_exp

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    final_report();
  end

  initial begin
    int n, c, d;
    logic [15:0] w;
    resetn = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    target = 3'h0;
    slow = 1'b0;
    device_idle = 1'b0;
    err_count = 0;
    checked = 0;
    istat = 0;
    idle = 0;
    halt = 0;
    for (n = 0; n < 3; n++) begin
      res[n] = 0;
      flg[n] = 0;
      on[n] = 0;
      inv[n] = 0;
      edg[n] = 0;
      rawm[n] = 0;
    end
    void'($urandom(24));
    repeat (4) @(posedge sys_clk);
    resetn <= 1'b1;
    for (n = 0; n < 16; n++) rd_chk(4'(n), 16'h0000);
    chk_pin({2'h0, lad_div}, 8'h20);
    for (n = 7; n < 16; n++) begin
      wr(4'(n), 16'($urandom));
      rd_chk(4'(n), 16'h0000);
    end
    for (n = 0; n < 8; n++) begin
      w = 16'($urandom);
      w[9:8] = n[1:0];
      w[5] = n[2];
      wr(IDX_LADDER, w);
      rd_chk(IDX_LADDER, w & 16'h07FF);
      repeat (2) @(posedge sys_clk);
      c = {lad_pwr, lad_pin, lad_rng, lad_sup, lad_lvl};
      chk_pin(8'(c), w[7:0]);
      chk_pin({5'h00, ext_pick, bg_sel}, {5'h00, w[10:8]});
      chk_pin({2'h0, lad_div}, w[5] ? 8'h18 : 8'h20);
    end
    for (n = 0; n < 48; n++) begin
      c = n % 3;
      imask = $urandom_range(7);
      halt = $urandom_range(1);
      w = 16'($urandom);
      w[2:0] = imask[2:0];
      wr(IDX_IRQ_MASK, w);
      w = 16'($urandom);
      w[15] = halt[0];
      wr(IDX_STATUS, w);
      on[c] = ($urandom_range(3) != 0);
      inv[c] = $urandom_range(1);
      // Junk in unimplemented and read-only positions must not stick
      w = 16'($urandom) & 16'h1D2C;
      w[15] = on[c][0];
      w[14] = $urandom_range(1);
      w[13] = inv[c][0];
      w[4] = $urandom_range(1);
      w[1:0] = n[1:0];
      wr(4'(c), w);
      edg[c] = 0;
      flg[c] = 0;
      step(c);
      repeat (8) @(posedge sys_clk);
      edg[c] = (n / 3) % 4;
      w[7:6] = edg[c][1:0];
      wr(4'(c), w);
      repeat (2) @(posedge sys_clk);
      chk_pin({7'h00, plus_src[c]}, {7'h00, w[4]});
      chk_pin({6'h00, minus_sel[2*c+:2]}, {6'h00, w[1:0]});
      chk_pin({7'h00, rpin_oe[c]}, {7'h00, w[14]});
      idle = $urandom_range(1);
      device_idle <= idle[0];
      for (d = $urandom_range(3, 1); d > 0; d--) begin
        @(posedge sys_clk);
        rawm[c] = rawm[c] ^ 1;
        // Delay choice settles before the model sees the new target
        slow <= 1'($urandom_range(1));
        @(negedge sys_clk);
        target[c] <= rawm[c][0];
        repeat (8) @(posedge sys_clk);
        chk_pin({7'h00, rpin[c]}, 8'(rawm[c] ^ inv[c]));
        step(c);
      end
      chk_pin({5'h00, cpwr}, pwr_exp());
      @(posedge sys_clk);
      device_idle <= 1'b0;
      idle = 0;
      step(c);
      repeat (8) @(posedge sys_clk);
      w = (w & 16'hE0D3) | 16'(flg[c] << 9) | 16'(res[c] << 8);
      rd_chk(4'(c), w);
      rd_chk(IDX_STATUS, stat_exp());
      chk_pin({7'h00, irq}, 8'((istat & imask) != 0));
      w = 16'($urandom);
      wr(IDX_IRQ_STAT, w);
      istat = istat & ~int'(w[2:0]);
      repeat (3) @(posedge sys_clk);
      rd_chk(IDX_IRQ_STAT, 16'(istat));
      chk_pin({7'h00, irq}, 8'((istat & imask) != 0));
    end
    final_report();
  end
endmodule : tb_triple_comparator_control
`default_nettype wire
